// File: inc/ata_cmd_pkg.sv
`default_nettype none
package ata_cmd_pkg;
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned CLK_NS          = 25;
  localparam int unsigned BSY_RISE_NS     = 400;
  localparam int unsigned BSY_RISE_CYC    = (BSY_RISE_NS / CLK_NS) < 1 ? 1 : BSY_RISE_NS / CLK_NS;
  localparam int unsigned READY_SEC       = 31;
  localparam int unsigned DIN_SEC         = 30;
  localparam int unsigned DIN_BSY_US      = 10;
  localparam int unsigned DOUT_DRQ_US     = 700;
  localparam int unsigned DOUT_BSY_US     = 5;
  localparam int unsigned DONE_SEC        = 30;
  localparam int unsigned SEC_FIRST_SEC   = 10;
  localparam int unsigned DIN_BSY_CYC     = DIN_BSY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DOUT_DRQ_CYC    = DOUT_DRQ_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DOUT_BSY_CYC    = DOUT_BSY_US * (CLK_HZ / 1_000_000);
  localparam int unsigned WORDS_PER_SECT  = 256;
  localparam int unsigned SECT_ZERO_CNT   = 256;
  localparam logic [7:0]  CMD_WR_SECT     = 8'h30;
  localparam logic [7:0]  CMD_WR_SECT_NR  = 8'h31;
  localparam logic [7:0]  CMD_WR_VERIFY   = 8'h3c;
  localparam logic [7:0]  CMD_SET_FEAT    = 8'hef;
  localparam logic [7:0]  FEAT_WCACHE_ON  = 8'h02;
  localparam logic [7:0]  FEAT_XFER_MODE  = 8'h03;
  localparam logic [7:0]  FEAT_WCACHE_OFF = 8'h82;
  localparam logic [1:0]  WCACHE_RST      = 2'h0;

  typedef enum logic [1:0] {
    CAT_NONDATA = 2'h0,
    CAT_DIN     = 2'h1,
    CAT_DOUT    = 2'h2,
    CAT_REJECT  = 2'h3
  } cmd_cat_t;

  typedef struct packed {
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_low;
    logic [7:0] cyl_high;
    logic       lba_mode;
    logic [3:0] head;
  } taskfile_t;

  typedef struct packed {
    logic busy;
    logic ready;
    logic drq;
    logic err;
    logic abort;
  } status_t;
endpackage
`default_nettype wire

// File: src/word_fifo.sv
`default_nettype none
module word_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two of at least 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q, wr_d, rd_q, rd_d;
  logic             push, pop;

  always_comb begin
    o_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
    o_valid = wr_q != rd_q;
    o_data  = mem_q[rd_q[AW-1:0]];
    push    = i_valid && o_ready;
    pop     = o_valid && i_ready;
    wr_d    = push ? wr_q + 1'b1 : wr_q;
    rd_d    = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
    if (push) mem_q[wr_q[AW-1:0]] <= i_data;
  end
endmodule
`default_nettype wire

// File: src/ata_write_cmd_timeout_ctrl.sv
`default_nettype none
// Notes on behaviour
// - Write-sectors payload arrives from the host as successive 16-bit data words.
// - With auto reassign off, an uncorrectable error stops the write at that sector.
// - A sector count of zero means 256 sectors.
// - In block-address mode the 28-bit address is head:cyl_high:cyl_low:sector.
// - In geometric mode sector, cylinder and head give the first sector.
// - Command bit 0 disables retries, but is ignored while write caching is on.
// - At the end the count register holds sectors not transferred, zero unless error.
// - At the end the address registers hold the last transferred sector's address.
// - Write-verify runs exactly like write-sectors, with no read-back.
// - Busy rises within 400 ns after power-on, hard reset, soft reset or any command; the code raises busy only for commands written in the idle state.
// - Busy clears and ready sets within 31 s after power-on or either reset.
// - Data-in commands reach data request and interrupt within 30 s of busy.
// - After the 256th data-in read busy sets within 10 us.
// - Data-out commands reach data request within 700 us of busy.
// - After the 256th data-out write busy sets within 5 us.
// - Data-out commands complete with interrupt within 30 s, secure erase exempt.
// - Non-data commands complete with interrupt within 30 s, format exempt.
// - A first security command after standby power-up may take 10 s to data request.
// - Set-features subcodes for write caching and transfer mode are accepted.
module ata_write_cmd_timeout_ctrl #(
  parameter int unsigned READY_CYC  = 200,
  parameter int unsigned EXEC_CYC   = 64,
  parameter int unsigned SECT_CYC   = 32,
  parameter int unsigned FIFO_DEPTH = 8
) (
  input  wire logic                   i_clock,
  input  wire logic                   i_rst,
  input  wire logic                   i_bus_reset,
  input  wire logic                   i_soft_reset,
  input  wire logic                   i_cmd_wr,
  input  wire logic [7:0]             i_cmd_code,
  input  wire logic [7:0]             i_feature,
  input  wire ata_cmd_pkg::taskfile_t i_taskfile,
  input  wire logic                   i_data_wr,
  input  wire logic [15:0]            i_data,
  input  wire logic                   i_data_rd,
  input  wire logic                   i_auto_reassign,
  output logic                        o_media_valid,
  output logic [15:0]                 o_media_data,
  input  wire logic                   i_media_ready,
  input  wire logic                   i_media_error,
  output logic                        o_fifo_ready,
  output ata_cmd_pkg::status_t        o_status,
  output ata_cmd_pkg::taskfile_t      o_taskfile,
  output logic [27:0]                 o_lba,
  output logic                        o_retry_off,
  output logic                        o_write_cache,
  output logic [7:0]                  o_xfer_mode,
  output logic                        o_irq
);
  import ata_cmd_pkg::*;

  initial begin
    if (READY_CYC < BSY_RISE_CYC || EXEC_CYC < 1 || SECT_CYC < 1) $error("Timing parameters too small");
  end

  typedef enum logic [6:0] {
    ST_RESET  = 7'h01,
    ST_IDLE   = 7'h02,
    ST_EXEC   = 7'h04,
    ST_DRQ_WR = 7'h08,
    ST_COMMIT = 7'h10,
    ST_DRQ_RD = 7'h20,
    ST_DONE   = 7'h40
  } state_t;

  logic       bus_rst_s1_q, bus_rst_s2_q, soft_s1_q, soft_s2_q, soft_prev_q;
  logic       cmd_s1_q, cmd_s2_q, cmd_prev_q, wr_s1_q, wr_s2_q, wr_prev_q;
  logic       rd_s1_q, rd_s2_q, rd_prev_q;
  logic [15:0] data_s1_q, data_s2_q;
  logic       cmd_pulse, wr_pulse, rd_pulse, soft_release;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      {bus_rst_s1_q, bus_rst_s2_q, soft_s1_q, soft_s2_q, soft_prev_q} <= '0;
      {cmd_s1_q, cmd_s2_q, cmd_prev_q, wr_s1_q, wr_s2_q, wr_prev_q} <= '0;
      {rd_s1_q, rd_s2_q, rd_prev_q} <= '0;
      data_s1_q <= 16'h0000;
      data_s2_q <= 16'h0000;
    end else begin
      {bus_rst_s2_q, bus_rst_s1_q} <= {bus_rst_s1_q, i_bus_reset};
      {soft_s2_q, soft_s1_q, soft_prev_q} <= {soft_s1_q, i_soft_reset, soft_s2_q};
      {cmd_s2_q, cmd_s1_q, cmd_prev_q} <= {cmd_s1_q, i_cmd_wr, cmd_s2_q};
      {wr_s2_q, wr_s1_q, wr_prev_q} <= {wr_s1_q, i_data_wr, wr_s2_q};
      {rd_s2_q, rd_s1_q, rd_prev_q} <= {rd_s1_q, i_data_rd, rd_s2_q};
      data_s1_q <= i_data;
      data_s2_q <= data_s1_q;
    end
  end

  assign cmd_pulse    = cmd_s2_q && !cmd_prev_q;
  assign wr_pulse     = wr_s2_q && !wr_prev_q;
  assign rd_pulse     = rd_s2_q && !rd_prev_q;
  assign soft_release = soft_prev_q && !soft_s2_q;

  state_t      state_q, state_d;
  cmd_cat_t    cat_q, cat_d;
  taskfile_t   tf_q, tf_d;
  logic [8:0]  left_q, left_d;
  logic [8:0]  word_q, word_d;
  logic [31:0] tmr_q, tmr_d;
  logic        err_q, err_d, abort_q, abort_d, irq_q, irq_d;
  logic        retry_off_q, retry_off_d, wcache_q, wcache_d;
  logic [7:0]  mode_q, mode_d;
  logic        fifo_ready, fifo_in_valid, any_reset;
  logic [8:0]  first_left;

  word_fifo #(
    .WIDTH(16),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clock(i_clock),
    .i_rst  (i_rst),
    .i_data (data_s2_q),
    .i_valid(fifo_in_valid),
    .o_ready(fifo_ready),
    .o_data (o_media_data),
    .o_valid(o_media_valid),
    .i_ready(i_media_ready)
  );

  assign fifo_in_valid = (state_q == ST_DRQ_WR) && wr_pulse;
  assign any_reset     = bus_rst_s2_q || soft_s2_q;
  assign first_left    = (tf_q.count == 8'h00) ? 9'(SECT_ZERO_CNT) : {1'b0, tf_q.count};

  function automatic cmd_cat_t classify(input logic [7:0] code);
    case (code)
      8'h30, 8'h31, 8'h3c, 8'hc5, 8'hca, 8'hcb, 8'he8, 8'hf1, 8'hf2, 8'hf4, 8'hf6: classify = CAT_DOUT;
      8'h20, 8'h21, 8'hc4, 8'hc8, 8'hc9, 8'he4, 8'hec, 8'hee:                       classify = CAT_DIN;
      8'h40, 8'h41, 8'h50, 8'h90, 8'h91, 8'hc6, 8'he0, 8'he1, 8'he2, 8'he3, 8'he5,
      8'he6, 8'he7, 8'hef, 8'hf3, 8'hf5, 8'hf7, 8'hf8, 8'hf9, 8'hb0:                 classify = CAT_NONDATA;
      default: begin
        if (code[7:4] == 4'h1 || code[7:4] == 4'h7) classify = CAT_NONDATA;
        else classify = CAT_REJECT;
      end
    endcase
  endfunction

  always_comb begin
    state_d     = state_q;
    cat_d       = cat_q;
    tf_d        = tf_q;
    left_d      = left_q;
    word_d      = word_q;
    tmr_d       = tmr_q + 32'h1;
    err_d       = err_q;
    abort_d     = abort_q;
    irq_d       = irq_q;
    retry_off_d = retry_off_q;
    wcache_d    = wcache_q;
    mode_d      = mode_q;
    case (state_q)
      ST_RESET: begin
        if (tmr_q >= 32'(READY_CYC)) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (cmd_pulse) begin
          state_d = ST_EXEC;
          tmr_d   = 32'h0;
          cat_d   = classify(i_cmd_code);
          tf_d    = i_taskfile;
          left_d  = (i_taskfile.count == 8'h00) ? 9'(SECT_ZERO_CNT) : {1'b0, i_taskfile.count};
          word_d  = 9'h0;
          err_d   = 1'b0;
          abort_d = 1'b0;
          irq_d   = 1'b0;
          retry_off_d = (i_cmd_code == CMD_WR_SECT_NR) && !wcache_q;
          if (i_cmd_code == CMD_SET_FEAT) begin
            if (i_feature == FEAT_WCACHE_ON) wcache_d = 1'b1;
            else if (i_feature == FEAT_WCACHE_OFF) wcache_d = 1'b0;
            else if (i_feature == FEAT_XFER_MODE) mode_d = i_taskfile.count;
          end
        end
      end
      ST_EXEC: begin
        if (tmr_q >= 32'(EXEC_CYC - 1)) begin
          tmr_d = 32'h0;
          case (cat_q)
            CAT_DOUT: state_d = ST_DRQ_WR;
            CAT_DIN: begin
              state_d = ST_DRQ_RD;
              irq_d   = 1'b1;
            end
            CAT_REJECT: begin
              state_d = ST_DONE;
              err_d   = 1'b1;
              abort_d = 1'b1;
              irq_d   = 1'b1;
            end
            default: begin
              state_d = ST_DONE;
              irq_d   = 1'b1;
            end
          endcase
        end
      end
      ST_DRQ_WR: begin
        if (fifo_in_valid) begin
          word_d = word_q + 9'h1;
          if (word_q == 9'(WORDS_PER_SECT - 1)) begin
            state_d = ST_COMMIT;
            word_d  = 9'h0;
            tmr_d   = 32'h0;
          end
        end
      end
      ST_COMMIT: begin
        if (!o_media_valid && tmr_q >= 32'(SECT_CYC - 1)) begin
          tmr_d = 32'h0;
          if (i_media_error && !i_auto_reassign) begin
            state_d = ST_DONE;
            err_d   = 1'b1;
            irq_d   = 1'b1;
            if (left_q != first_left) begin
              if (tf_q.lba_mode) begin
                {tf_d.head, tf_d.cyl_high, tf_d.cyl_low, tf_d.sector} =
                  {tf_q.head, tf_q.cyl_high, tf_q.cyl_low, tf_q.sector} - 28'h1;
              end else begin
                tf_d.sector = tf_q.sector - 8'h1;
              end
            end
          end else begin
            left_d = left_q - 9'h1;
            if (left_q == 9'h1) begin
              state_d = ST_DONE;
              irq_d   = 1'b1;
            end else begin
              state_d = ST_DRQ_WR;
              if (tf_q.lba_mode) begin
                {tf_d.head, tf_d.cyl_high, tf_d.cyl_low, tf_d.sector} =
                  {tf_q.head, tf_q.cyl_high, tf_q.cyl_low, tf_q.sector} + 28'h1;
              end else begin
                tf_d.sector = tf_q.sector + 8'h1;
              end
            end
          end
        end
      end
      ST_DRQ_RD: begin
        if (rd_pulse) begin
          word_d = word_q + 9'h1;
          if (word_q == 9'(WORDS_PER_SECT - 1)) begin
            state_d = ST_DONE;
            irq_d   = 1'b1;
          end
        end
      end
      ST_DONE: begin
        state_d = ST_IDLE;
      end
      default: state_d = ST_RESET;
    endcase
    if (any_reset || soft_release) begin
      state_d = ST_RESET;
      tmr_d   = 32'h0;
      irq_d   = 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_q     <= ST_RESET;
      cat_q       <= CAT_NONDATA;
      tf_q        <= '0;
      left_q      <= 9'h0;
      word_q      <= 9'h0;
      tmr_q       <= 32'h0;
      err_q       <= 1'b0;
      abort_q     <= 1'b0;
      irq_q       <= 1'b0;
      retry_off_q <= 1'b0;
      wcache_q    <= WCACHE_RST[0];
      mode_q      <= 8'h00;
    end else begin
      state_q     <= state_d;
      cat_q       <= cat_d;
      tf_q        <= tf_d;
      left_q      <= left_d;
      word_q      <= word_d;
      tmr_q       <= tmr_d;
      err_q       <= err_d;
      abort_q     <= abort_d;
      irq_q       <= irq_d;
      retry_off_q <= retry_off_d;
      wcache_q    <= wcache_d;
      mode_q      <= mode_d;
    end
  end

  always_comb begin
    o_status.busy  = (state_q == ST_RESET) || (state_q == ST_EXEC) || (state_q == ST_COMMIT)
                  || (state_q == ST_DONE);
    o_status.ready = !o_status.busy;
    o_status.drq   = (state_q == ST_DRQ_WR) || (state_q == ST_DRQ_RD);
    o_status.err   = err_q;
    o_status.abort = abort_q;
    o_taskfile     = tf_q;
    o_taskfile.count = left_q[7:0];
    o_lba          = {tf_q.head, tf_q.cyl_high, tf_q.cyl_low, tf_q.sector};
    o_retry_off    = retry_off_q;
    o_write_cache  = wcache_q;
    o_xfer_mode    = mode_q;
    o_irq          = irq_q;
    o_fifo_ready   = fifo_ready;
  end
endmodule
`default_nettype wire

// File: dv/ata_cmd_checker.sv
`default_nettype none
module ata_cmd_checker
  import ata_cmd_pkg::*;
#(
  parameter int unsigned READY_CYC = 200
) (
  input wire logic                 i_clock,
  input wire logic                 i_rst,
  input wire logic                 i_bus_reset,
  input wire logic                 i_soft_reset,
  input wire logic                 i_cmd_wr,
  input wire logic                 i_data_wr,
  input wire logic                 i_data_rd,
  input wire ata_cmd_pkg::status_t o_status,
  input wire logic                 o_irq
);
  localparam int RDY_MAX = READY_CYC + 8;
  logic [8:0] cnt_q;
  logic [8:0] cnt_d;
  logic       wr_q;
  logic       rd_q;
  // Counts data strobes accepted during one data request.
  always_comb begin
    cnt_d = cnt_q;
    if (o_status.busy) begin
      cnt_d = 9'h000;
    end else if (o_status.drq && ((i_data_wr && !wr_q) || (i_data_rd && !rd_q))) begin
      cnt_d = cnt_q + 9'h001;
    end
  end
  always_ff @(posedge i_clock) begin
    cnt_q <= i_rst ? 9'h000 : cnt_d;
    wr_q  <= i_data_wr;
    rd_q  <= i_data_rd;
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  a_busy_in_rst: assert property (disable iff (1'b0) i_rst |=> o_status.busy)
    else $error("busy missing after power-on reset");
  a_ready_after_rst: assert property ($fell(i_rst) |-> ##[1:RDY_MAX] (o_status.ready && !o_status.busy))
    else $error("ready late after power-on reset");
  a_soft_ready: assert property ($fell(i_soft_reset) |-> ##[1:RDY_MAX] (o_status.ready && !o_status.busy))
    else $error("ready late after soft reset");
  a_cmd_busy: assert property ($rose(i_cmd_wr) && o_status.ready |-> ##[1:16] o_status.busy)
    else $error("busy late after command");
  a_soft_busy: assert property ($rose(i_soft_reset) |-> ##[1:16] o_status.busy)
    else $error("busy late after soft reset");
  a_bus_busy: assert property ($rose(i_bus_reset) |-> ##[1:16] o_status.busy)
    else $error("busy late after bus reset");
  a_drq_not_busy: assert property (o_status.drq |-> !o_status.busy)
    else $error("data request shown while busy");
  a_irq_idle: assert property ($rose(o_irq) |-> ##[0:1] !o_status.busy)
    else $error("interrupt raised while busy");
  a_abort_irq: assert property ($rose(o_status.abort) |-> ##[0:2] (o_irq && o_status.err))
    else $error("abort without error and interrupt");
  a_last_word_busy: assert property (i_data_wr && !wr_q && o_status.drq && cnt_q == 9'h0ff
                                     |-> ##[1:200] o_status.busy)
    else $error("busy late after last word");
  a_last_read_busy: assert property (i_data_rd && !rd_q && o_status.drq && cnt_q == 9'h0ff
                                     |-> ##[1:8] o_status.busy)
    else $error("busy late after last read");
  c_read: cover property (i_data_rd && !rd_q && o_status.drq && cnt_q == 9'h0ff);
  c_drq: cover property ($rose(o_status.drq));
  c_abort: cover property ($rose(o_status.abort));
  c_done: cover property ($rose(o_irq) && !o_status.err);
endmodule
bind ata_write_cmd_timeout_ctrl ata_cmd_checker #(.READY_CYC(READY_CYC)) ata_cmd_checker_inst (
  .i_clock(i_clock), .i_rst(i_rst), .i_bus_reset(i_bus_reset), .i_soft_reset(i_soft_reset),
  .i_cmd_wr(i_cmd_wr), .i_data_wr(i_data_wr), .i_data_rd(i_data_rd), .o_status(o_status), .o_irq(o_irq));
`default_nettype wire

// File: dv/ata_host_model.sv
`default_nettype none
module ata_host_model
  import ata_cmd_pkg::*;
(
  input  wire logic             i_clock,
  input  wire logic             i_fifo_ready,
  output logic                  o_cmd_wr,
  output logic [7:0]            o_cmd_code,
  output logic [7:0]            o_feature,
  output ata_cmd_pkg::taskfile_t o_taskfile,
  output logic                  o_data_wr,
  output logic [15:0]           o_data,
  output logic                  o_data_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] word_q = 16'h0000;
  initial begin
    o_cmd_wr = 1'b0;
    o_cmd_code = 8'h00;
    o_feature = 8'h00;
    o_taskfile = '0;
    o_data_wr = 1'b0;
    o_data = 16'hffff;
    o_data_rd = 1'b0;
  end
  task automatic send_cmd(input logic [7:0] code, input logic [7:0] feat, input taskfile_t tf);
    @(negedge i_clock);
    o_cmd_code = code;
    o_feature = feat;
    o_taskfile = tf;
    o_cmd_wr = 1'b1;
    repeat (3) @(negedge i_clock);
    o_cmd_wr = 1'b0;
    repeat (4) @(negedge i_clock);
  endtask
  // Each payload unit is one whole 16-bit word; the bus shows its inverse once released.
  task automatic write_words(input int n);
    for (int i = 0; i < n; i++) begin
      for (int k = 0; k < 100 && !i_fifo_ready; k++) @(negedge i_clock);
      o_data = word_q;
      o_data_wr = 1'b1;
      repeat (2) @(negedge i_clock);
      o_data_wr = 1'b0;
      o_data = ~word_q;
      word_q = word_q + 16'h0001;
      repeat (3) @(negedge i_clock);
    end
  endtask
  task automatic read_words(input int n);
    for (int i = 0; i < n; i++) begin
      o_data_rd = 1'b1;
      repeat (2) @(negedge i_clock);
      o_data_rd = 1'b0;
      repeat (3) @(negedge i_clock);
    end
  endtask
endmodule
`default_nettype wire

// File: dv/ata_write_cmd_timeout_ctrl_tb_top.sv
`default_nettype none
module ata_write_cmd_timeout_ctrl_tb_top
  import ata_cmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        bus_rst = 1'b0;
  logic        soft_rst = 1'b0;
  logic        reassign = 1'b1;
  logic        media_rdy = 1'b1;
  logic        media_err = 1'b0;
  logic        fail_armed = 1'b0;
  logic        stall = 1'b0;
  logic        cmd_wr, data_wr, data_rd, fifo_rdy, media_vld, irq, retry_off, wcache;
  logic [7:0]  code, feat, xfer;
  logic [15:0] data, media_data;
  logic [27:0] lba;
  logic [15:0] exp_word = 16'h0000;
  taskfile_t   tf_in, tf_out;
  status_t     st;
  int          n_errors = 0;
  int          n_checks = 0;
  always #12.5 i_clock = ~i_clock;
  always @(negedge i_clock) media_rdy <= !stall;
  ata_write_cmd_timeout_ctrl #(.READY_CYC(40)) ata_write_cmd_timeout_ctrl_inst (
    .i_clock(i_clock), .i_rst(i_rst), .i_bus_reset(bus_rst), .i_soft_reset(soft_rst),
    .i_cmd_wr(cmd_wr), .i_cmd_code(code), .i_feature(feat), .i_taskfile(tf_in),
    .i_data_wr(data_wr), .i_data(data), .i_data_rd(data_rd), .i_auto_reassign(reassign),
    .o_media_valid(media_vld), .o_media_data(media_data), .i_media_ready(media_rdy),
    .i_media_error(media_err), .o_fifo_ready(fifo_rdy), .o_status(st), .o_taskfile(tf_out),
    .o_lba(lba), .o_retry_off(retry_off), .o_write_cache(wcache), .o_xfer_mode(xfer), .o_irq(irq));
  ata_host_model ata_host_model_inst (
    .i_clock(i_clock), .i_fifo_ready(fifo_rdy), .o_cmd_wr(cmd_wr), .o_cmd_code(code),
    .o_feature(feat), .o_taskfile(tf_in), .o_data_wr(data_wr), .o_data(data), .o_data_rd(data_rd));
  always @(posedge i_clock) begin
    if (!i_rst && media_vld && media_rdy) begin
      n_checks++;
      if (media_data !== exp_word) begin
        $display("ERROR media_data expected %h seen %h", exp_word, media_data);
        n_errors++;
      end
      exp_word++;
    end
    if (!fail_armed) media_err <= 1'b0;
    else if (media_vld && media_rdy) media_err <= 1'b1;
  end
  task automatic stop_test();
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask
  // Waits for 0 idle, 1 data request, 2 completion.
  task automatic wait_on(input int which);
    for (int k = 0; k < 5000; k++) begin
      @(negedge i_clock);
      if (which == 0 && st.ready === 1'b1 && st.busy === 1'b0) return;
      if (which == 1 && st.drq === 1'b1) return;
      if (which == 2 && irq === 1'b1 && st.busy === 1'b0) return;
    end
    $display("ERROR wait %0d expected 1 seen 0", which);
    n_errors++;
    stop_test();
  endtask
  task automatic cmd(input logic [7:0] c, input logic [7:0] f, input taskfile_t tf);
    wait_on(0);
    ata_host_model_inst.send_cmd(c, f, tf);
  endtask
  task automatic t_reset();
    repeat (3) @(negedge i_clock);
    check("busy", 1, st.busy);
    i_rst = 1'b0;
    wait_on(0);
  endtask
  task automatic t_write_lba();
    stall = 1'b1;
    cmd(CMD_WR_SECT, 8'h00, '{8'h02, 8'h34, 8'h12, 8'h56, 1'b1, 4'h7});
    wait_on(1);
    ata_host_model_inst.write_words(8);
    repeat (6) @(negedge i_clock);
    check("fifo_ready", 0, fifo_rdy);
    stall = 1'b0;
    ata_host_model_inst.write_words(248);
    wait_on(1);
    ata_host_model_inst.write_words(256);
    wait_on(2);
    check("count", 0, tf_out.count);
    check("lba", 28'h7561235, lba);
  endtask
  task automatic t_error_stop();
    reassign = 1'b0;
    cmd(CMD_WR_VERIFY, 8'h00, '{8'h00, 8'h05, 8'h00, 8'h01, 1'b0, 4'h2});
    wait_on(1);
    ata_host_model_inst.write_words(256);
    wait_on(1);
    fail_armed = 1'b1;
    ata_host_model_inst.write_words(256);
    wait_on(2);
    fail_armed = 1'b0;
    reassign = 1'b1;
    check("count", 8'hff, tf_out.count);
    check("drq", 0, st.drq);
    check("err", 1, st.err);
    check("sector", 8'h05, tf_out.sector);
  endtask
  task automatic t_features();
    cmd(CMD_SET_FEAT, FEAT_WCACHE_ON, '0);
    wait_on(2);
    check("wcache", 1, wcache);
    cmd(CMD_SET_FEAT, FEAT_XFER_MODE, '{8'h0c, 8'h01, 8'h00, 8'h00, 1'b1, 4'h0});
    wait_on(2);
    check("xfer", 8'h0c, xfer);
    for (int i = 0; i < 2; i++) begin
      cmd(CMD_WR_SECT_NR, 8'h00, '{8'h01, 8'h01, 8'h00, 8'h00, 1'b1, 4'h0});
      wait_on(1);
      check("retry_off", i, retry_off);
      ata_host_model_inst.write_words(256);
      wait_on(2);
      cmd(CMD_SET_FEAT, FEAT_WCACHE_OFF, '0);
      wait_on(2);
    end
  endtask
  task automatic t_codes();
    logic [7:0] bad [7] = '{8'hc7, 8'hcc, 8'ha0, 8'ha1, 8'hde, 8'hdf, 8'hed};
    logic [7:0] good [7] = '{8'hc6, 8'hc4, 8'hc5, 8'hc8, 8'hc9, 8'hca, 8'hcb};
    foreach (bad[i]) begin
      cmd(bad[i], 8'h00, '0);
      wait_on(2);
      check("abort", 1, st.abort);
      check("err", 1, st.err);
    end
    foreach (good[i]) begin
      cmd(good[i], 8'h00, '{8'h10, 8'h01, 8'h00, 8'h00, 1'b1, 4'h0});
      repeat (80) @(negedge i_clock);
      check("abort", 0, st.abort);
      if (st.busy !== 1'b0 || st.drq !== 1'b0) begin
        soft_rst = 1'b1;
        repeat (3) @(negedge i_clock);
        check("busy", 1, st.busy);
        soft_rst = 1'b0;
        wait_on(0);
      end
    end
  endtask
  task automatic t_read();
    cmd(8'h20, 8'h00, '{8'h01, 8'h09, 8'h00, 8'h00, 1'b1, 4'h0});
    wait_on(1);
    check("irq", 1, irq);
    ata_host_model_inst.read_words(256);
    check("drq", 0, st.drq);
    check("busy", 0, st.busy);
  endtask
  task automatic t_bus_reset();
    bus_rst = 1'b1;
    repeat (4) @(negedge i_clock);
    check("busy", 1, st.busy);
    bus_rst = 1'b0;
    wait_on(0);
    check("ready", 1, st.ready);
  endtask
  initial begin
    t_reset();
    t_write_lba();
    t_error_stop();
    t_features();
    t_codes();
    t_read();
    t_bus_reset();
    stop_test();
  end
endmodule
`default_nettype wire
